// ### pdmi_amp.sv
// Amplifier end: PDM receiver, pattern control, power states, modulator
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "pdmi_map.svh"
// Functional notes
// RULE1: Source clock synchronous with its data
// RULE2: Bit clock within 1.84-3.23 or 3.68-6.46 MHz
// RULE3: Capture strap once supplies come up
// RULE4: 128 stop bytes enter standby
// RULE5: Clock loss in standby means full power-down
// RULE6: Non-stop byte after restart resumes operation
// RULE7: Low supply holds logic reset, output off
// RULE8: Strap decodes rate and gain four ways
// RULE9: Gain scales output per gain setting
// RULE10: Separate decimation paths for 64x and 128x
// RULE11: Source should prefer 64x rate
// RULE12: Patterns act after 128 repeats
// RULE13: Mute while control pattern detected
// RULE14: Clock-loss power-down restores pattern defaults
// RULE15: Stop pattern switches all but interface off
// RULE16: Gain patterns override strap gain
// RULE17: Rate pattern inverts strap rate
// RULE18: Pattern enables ultralow emission mode
// RULE19: Patterns enable half pulse, 32 kHz mode
// RULE20: Three-level modulator, density follows level
// RULE21: Channel strap low right, high left
// RULE22: Source keeps data stable in sample window
// RULE23: Left on rising edge, right on falling
// RULE24: Count consecutive identical bytes, restart on mismatch
module pdmi_amp #(
    parameter int REPEAT_MIN = `PDMI_REPEAT_MIN,
    parameter int LOSS_CYC = `PDMI_LOSS_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // Supplies and straps
    input wire logic power_stage_supply_ok,
    input wire logic vdd_ok,
    input wire logic smart_pd_en,
    input wire logic gain_rate_strap_high,
    input wire logic gain_rate_strap_direct,
    input wire logic channel_select_strap,
    // Link
    pdmi_link_if.amp link,
    // Power stage
    output logic out_pos,
    output logic out_neg,
    // Status
    output logic muted,
    output pdmi_pkg::pdmi_pwr_e pwr_state,
    output pdmi_pkg::pdmi_gain_e gain_sel,
    output logic rate_128,
    output logic emi_low,
    output logic half_pulse,
    output logic special_32k
);
    localparam int LW = $clog2(LOSS_CYC + 1);
    localparam logic [LW-1:0] LMAX = LW'(LOSS_CYC);
    logic clk_d_ff;
    logic [7:0] shift_ff;
    logic [2:0] bit_ff;
    logic skip_ff;
    logic [LW-1:0] loss_ff;
    logic cfg_ok_ff;
    logic strap_fast_ff;
    pdmi_pkg::pdmi_gain_e strap_gain_ff;
    pdmi_pkg::pdmi_gain_e gain_ff;
    pdmi_pkg::pdmi_pwr_e pwr_ff;
    logic flip_ff;
    logic emi_ff;
    logic half_ff;
    logic sp32_ff;
    logic muted_ff;
    logic [7:0] win_ff;
    logic [7:0] ones_ff;
    logic signed [15:0] xs_ff;
    logic signed [15:0] acc_ff;
    logic pos_ff;
    logic neg_ff;
    logic rate_ff;
    logic hit;
    logic hit_pulse;
    logic [7:0] pat;
    // RULE7: supply supervisor reset
    wire sup_rst = ~(power_stage_supply_ok & vdd_ok);
    wire clk_rise = link.pdm_clk & ~clk_d_ff;
    wire clk_fall = ~link.pdm_clk & clk_d_ff;
    // RULE21: channel strap select
    // RULE23: channel edge choice
    wire samp_edge = channel_select_strap ? clk_rise : clk_fall;
    wire samp = samp_edge & ~skip_ff;
    wire [7:0] nxt_shift = {shift_ff[6:0], link.pdm_serial_bit};
    wire byte_done = samp & (&bit_ff);
    wire clock_lost = loss_ff == LMAX;
    wire is_stop = nxt_shift == `PDMI_PAT_STOP;
    wire known = (pat == `PDMI_PAT_STOP) || (pat == `PDMI_PAT_G5V) ||
        (pat == `PDMI_PAT_G3V6) || (pat == `PDMI_PAT_G2V5) || (pat == `PDMI_PAT_RATE) ||
        (pat == `PDMI_PAT_EMI) || (pat == `PDMI_PAT_HALF) || (pat == `PDMI_PAT_SP32);
    // RULE14: clock-loss power-down restores defaults
    wire restore = clock_lost & (pwr_ff == pdmi_pkg::PDMI_STANDBY);
    // RULE17: opposite of strap rate
    wire rate_now = (strap_fast_ff ^ flip_ff) | sp32_ff;
    // RULE8: strap decode
    wire cap_fast = ~gain_rate_strap_high;
    wire pdmi_pkg::pdmi_gain_e cap_gain = gain_rate_strap_direct ? pdmi_pkg::PDMI_G3V6
        : pdmi_pkg::PDMI_G5V;
    // RULE24: repeat counting detector
    pdmi_pat_det #(.REPEAT_MIN(REPEAT_MIN)) u_det (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .clr(sup_rst | clock_lost),
        .byte_valid(byte_done),
        .byte_in(nxt_shift),
        .hit(hit),
        .hit_pulse(hit_pulse),
        .pat(pat)
    );
    // Bit receiver and clock-loss timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_d_ff <= 1'b0;
            shift_ff <= 8'h00;
            bit_ff <= 3'h0;
            skip_ff <= 1'b1;
            loss_ff <= '0;
        end else if (clk_en) begin
            clk_d_ff <= link.pdm_clk;
            if (sup_rst || clock_lost) begin
                bit_ff <= 3'h0;
                // First rise after loss already spent
                skip_ff <= channel_select_strap & ~clock_lost;
            end else if (samp_edge) begin
                skip_ff <= 1'b0;
            end
            if (samp && !sup_rst && !clock_lost) begin
                shift_ff <= nxt_shift;
                bit_ff <= bit_ff + 3'h1;
            end
            if (clk_rise || clk_fall || sup_rst) begin
                loss_ff <= '0;
            end else if (!clock_lost) begin
                loss_ff <= loss_ff + LW'(1);
            end
        end
    end
    // RULE3: strap capture after supplies come up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ok_ff <= 1'b0;
            strap_fast_ff <= 1'b0;
            strap_gain_ff <= pdmi_pkg::PDMI_G5V;
            rate_ff <= 1'b0;
        end else if (clk_en) begin
            rate_ff <= strap_fast_ff ^ flip_ff;
            if (sup_rst) begin
                cfg_ok_ff <= 1'b0;
            end else if (!cfg_ok_ff) begin
                cfg_ok_ff <= 1'b1;
                strap_fast_ff <= cap_fast;
                strap_gain_ff <= cap_gain;
            end
        end
    end
    // Pattern settings and power state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_ff <= pdmi_pkg::PDMI_G5V;
            flip_ff <= 1'b0;
            emi_ff <= 1'b0;
            half_ff <= 1'b0;
            sp32_ff <= 1'b0;
            pwr_ff <= pdmi_pkg::PDMI_RUN;
        end else if (clk_en) begin
            if (sup_rst || !cfg_ok_ff || restore) begin
                gain_ff <= sup_rst ? pdmi_pkg::PDMI_G5V : (cfg_ok_ff ? strap_gain_ff : cap_gain);
                flip_ff <= 1'b0;
                emi_ff <= 1'b0;
                half_ff <= 1'b0;
                sp32_ff <= 1'b0;
                // RULE5: clock absence in standby
                pwr_ff <= (restore && !sup_rst) ? pdmi_pkg::PDMI_OFF : pdmi_pkg::PDMI_RUN;
            end else if (hit_pulse) begin
                case (pat)
                    // RULE4: stop bytes enter standby
                    // RULE15: stop pattern powers down
                    `PDMI_PAT_STOP: begin
                        if (smart_pd_en) begin
                            pwr_ff <= pdmi_pkg::PDMI_STANDBY;
                        end
                    end
                    // RULE16: gain overrides
                    `PDMI_PAT_G5V: gain_ff <= pdmi_pkg::PDMI_G5V;
                    `PDMI_PAT_G3V6: gain_ff <= pdmi_pkg::PDMI_G3V6;
                    `PDMI_PAT_G2V5: gain_ff <= pdmi_pkg::PDMI_G2V5;
                    `PDMI_PAT_RATE: flip_ff <= 1'b1;
                    // RULE18: low emission mode
                    `PDMI_PAT_EMI: emi_ff <= 1'b1;
                    // RULE19: half pulse and 32 kHz modes
                    `PDMI_PAT_HALF: half_ff <= 1'b1;
                    `PDMI_PAT_SP32: sp32_ff <= 1'b1;
                    default: pwr_ff <= pwr_ff;
                endcase
            end else if (byte_done && !is_stop && pwr_ff != pdmi_pkg::PDMI_RUN) begin
                // RULE6: wake on non-stop byte
                pwr_ff <= pdmi_pkg::PDMI_RUN;
            end
        end
    end
    // RULE10: per-rate decimation paths
    wire [7:0] win_last = rate_now ? `PDMI_WIN128 : `PDMI_WIN64;
    wire [7:0] nxt_ones = ones_ff + {7'h00, link.pdm_serial_bit};
    wire signed [8:0] d64 = $signed({1'b0, nxt_ones}) - `PDMI_HALF64;
    wire signed [8:0] d128 = ($signed({1'b0, nxt_ones}) - `PDMI_HALF128) >>> 1;
    wire signed [8:0] pcm = rate_now ? d128 : d64;
    // RULE9: gain scaling
    wire [4:0] gk = gain_ff == pdmi_pkg::PDMI_G5V ? `PDMI_GK_5V
        : (gain_ff == pdmi_pkg::PDMI_G3V6 ? `PDMI_GK_3V6 : `PDMI_GK_2V5);
    wire signed [14:0] xs = pcm * $signed({1'b0, gk});
    // RULE20: three-level sigma-delta step
    wire signed [15:0] sum = acc_ff + xs_ff;
    wire go_pos = sum >= `PDMI_MOD_TH;
    wire go_neg = sum <= -`PDMI_MOD_TH;
    wire signed [15:0] nxt_acc = go_pos ? sum - `PDMI_MOD_FS
        : (go_neg ? sum + `PDMI_MOD_FS : sum);
    wire active = (pwr_ff == pdmi_pkg::PDMI_RUN) & ~muted_ff & ~sup_rst & cfg_ok_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_ff <= 8'h00;
            ones_ff <= 8'h00;
            xs_ff <= 16'sh0000;
        end else if (clk_en && samp) begin
            win_ff <= (win_ff >= win_last) ? 8'h00 : win_ff + 8'h01;
            ones_ff <= (win_ff >= win_last) ? 8'h00 : nxt_ones;
            if (win_ff >= win_last) begin
                xs_ff <= 16'(xs);
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ff <= 16'sh0000;
            pos_ff <= 1'b0;
            neg_ff <= 1'b0;
            muted_ff <= 1'b0;
        end else if (clk_en) begin
            // RULE13: mute on detected pattern
            muted_ff <= hit & known & ~sup_rst;
            if (!active) begin
                acc_ff <= 16'sh0000;
                pos_ff <= 1'b0;
                neg_ff <= 1'b0;
            end else if (samp) begin
                acc_ff <= nxt_acc;
                pos_ff <= go_pos;
                neg_ff <= go_neg;
            end else if (half_ff && (clk_rise || clk_fall)) begin
                pos_ff <= 1'b0;
                neg_ff <= 1'b0;
            end
        end
    end
    assign out_pos = pos_ff;
    assign out_neg = neg_ff;
    assign muted = muted_ff;
    assign pwr_state = pwr_ff;
    assign gain_sel = gain_ff;
    assign rate_128 = rate_ff;
    assign emi_low = emi_ff;
    assign half_pulse = half_ff;
    assign special_32k = sp32_ff;
endmodule : pdmi_amp

// ### pdmi_map.svh
// Offsets, codes, field positions and timing counts of the PDM link blocks
`ifndef PDMI_MAP_SVH
`define PDMI_MAP_SVH
// Control patterns
`define PDMI_PAT_STOP 8'hac
`define PDMI_PAT_G5V 8'hd8
`define PDMI_PAT_G3V6 8'hd4
`define PDMI_PAT_G2V5 8'hd2
`define PDMI_PAT_RATE 8'hd1
`define PDMI_PAT_EMI 8'he1
`define PDMI_PAT_HALF 8'he2
`define PDMI_PAT_SP32 8'he4
`define PDMI_REPEAT_MIN 128
// Timing
`define PDMI_CLK_NS 20
`define PDMI_LOSS_NS 10000
`define PDMI_LOSS_CYC ((`PDMI_LOSS_NS + `PDMI_CLK_NS - 1) / `PDMI_CLK_NS)
`define PDMI_DIV_SLOW 4'h7
`define PDMI_DIV_FAST 4'h3
// Decimation and modulator
`define PDMI_WIN64 8'h3f
`define PDMI_WIN128 8'h7f
`define PDMI_HALF64 9'sh020
`define PDMI_HALF128 9'sh040
`define PDMI_GK_5V 5'h14
`define PDMI_GK_3V6 5'h0e
`define PDMI_GK_2V5 5'h0a
`define PDMI_MOD_FS 16'sh0500
`define PDMI_MOD_TH 16'sh0280
// Source register map
`define PDMI_REG_CTRL 8'h00
`define PDMI_REG_AUDIO 8'h04
`define PDMI_REG_CMD 8'h08
`define PDMI_REG_STATUS 8'h0c
`define PDMI_CTRL_RUN 0
`define PDMI_CTRL_LEFT 1
`define PDMI_CTRL_FAST 2
`define PDMI_CTRL_RST 3'h0
`define PDMI_AUDIO_RST 8'h55
`define PDMI_CMD_CNT_LSB 8
`define PDMI_CMD_CNT_MSB 23
`define PDMI_CNT_MIN 16'h0080
`endif

// ### pdmi_pkg.sv
// Types shared by the PDM link blocks
package pdmi_pkg;
    typedef enum logic [1:0] {PDMI_G5V, PDMI_G3V6, PDMI_G2V5} pdmi_gain_e;
    typedef enum logic [1:0] {PDMI_RUN, PDMI_STANDBY, PDMI_OFF} pdmi_pwr_e;
endpackage : pdmi_pkg

// ### pdmi_link_if.sv
// PDM link between source and amplifier
`timescale 1ns/1ns
interface pdmi_link_if;
    logic pdm_clk;
    logic pdm_serial_bit;
    modport src (output pdm_clk, output pdm_serial_bit);
    modport amp (input pdm_clk, input pdm_serial_bit);
endinterface : pdmi_link_if

// ### pdmi_pat_det.sv
// Repeated byte pattern detector
`timescale 1ns/1ns
`include "pdmi_map.svh"
module pdmi_pat_det #(
    parameter int REPEAT_MIN = `PDMI_REPEAT_MIN
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic clr,
    // Received bytes
    input wire logic byte_valid,
    input wire logic [7:0] byte_in,
    // Detection
    output logic hit,
    output logic hit_pulse,
    output logic [7:0] pat
);
    localparam int CW = $clog2(REPEAT_MIN + 1);
    localparam logic [CW-1:0] CMAX = CW'(REPEAT_MIN);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic [7:0] prev_ff;
    logic pulse_ff;
    wire same = byte_in == prev_ff;
    // RULE24: count identical repeats
    assign nxt_cnt = !same ? CW'(1) : (cnt_ff == CMAX ? cnt_ff : cnt_ff + CW'(1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
            prev_ff <= 8'h00;
            pulse_ff <= 1'b0;
        end else if (clk_en) begin
            pulse_ff <= 1'b0;
            if (clr) begin
                cnt_ff <= '0;
            end else if (byte_valid) begin
                cnt_ff <= nxt_cnt;
                prev_ff <= byte_in;
                // RULE12: act at repeat threshold
                pulse_ff <= (nxt_cnt == CMAX) && (cnt_ff != CMAX);
            end
        end
    end
    assign hit = cnt_ff == CMAX;
    assign hit_pulse = pulse_ff;
    assign pat = prev_ff;
endmodule : pdmi_pat_det

// ### pdmi_src.sv
// Source end: AHB-Lite controlled PDM stream generator
`timescale 1ns/1ns
`include "pdmi_map.svh"
module pdmi_src (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Link
    pdmi_link_if.src link
);
    logic wr_ff;
    logic [7:0] addr_ff;
    logic [31:0] rdata_ff;
    logic ready_ff;
    logic [2:0] ctrl_ff;
    logic [7:0] audio_ff;
    logic [7:0] cmd_ff;
    logic [15:0] rep_ff;
    logic [3:0] div_ff;
    logic pclk_ff;
    logic data_ff;
    logic [7:0] sh_ff;
    logic [2:0] bitc_ff;
    wire ap = hsel & htrans[1] & hready;
    wire dp_wr = wr_ff & hready;
    wire busy = rep_ff != 16'h0000;
    wire [15:0] cnt_in = hwdata[`PDMI_CMD_CNT_MSB:`PDMI_CMD_CNT_LSB];
    wire [7:0] ra = haddr[7:0];
    wire [31:0] rd_mux = (ra == `PDMI_REG_CTRL) ? {29'h0, ctrl_ff}
        : (ra == `PDMI_REG_AUDIO) ? {24'h0, audio_ff}
        : (ra == `PDMI_REG_CMD) ? {8'h00, rep_ff, cmd_ff}
        : (ra == `PDMI_REG_STATUS) ? {30'h0, pclk_ff, busy} : 32'h0;
    // RULE2: divider for the two bit clock bands
    wire [3:0] half = ctrl_ff[`PDMI_CTRL_FAST] ? `PDMI_DIV_FAST : `PDMI_DIV_SLOW;
    wire tick = (div_ff == half) & (ctrl_ff[`PDMI_CTRL_RUN] | pclk_ff);
    wire rise = tick & ~pclk_ff;
    wire fall = tick & pclk_ff;
    // RULE22: change data on the edge away from sampling
    wire upd = ctrl_ff[`PDMI_CTRL_LEFT] ? fall : rise;
    wire [7:0] next_byte = busy ? cmd_ff : audio_ff;
    wire stopped = ~ctrl_ff[`PDMI_CTRL_RUN] & ~pclk_ff;
    // Register slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            addr_ff <= 8'h00;
            rdata_ff <= 32'h0;
            ready_ff <= 1'b1;
        end else if (clk_en) begin
            if (hready) begin
                wr_ff <= ap & hwrite;
                addr_ff <= ra;
                rdata_ff <= (ap & ~hwrite) ? rd_mux : 32'h0;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= `PDMI_CTRL_RST;
            audio_ff <= `PDMI_AUDIO_RST;
            cmd_ff <= 8'h00;
            rep_ff <= 16'h0000;
        end else if (clk_en) begin
            if (dp_wr && addr_ff == `PDMI_REG_CTRL) begin
                ctrl_ff <= hwdata[2:0];
            end
            if (dp_wr && addr_ff == `PDMI_REG_AUDIO) begin
                audio_ff <= hwdata[7:0];
            end
            if (dp_wr && addr_ff == `PDMI_REG_CMD) begin
                cmd_ff <= hwdata[7:0];
                // RULE12: at least the minimum repeats
                rep_ff <= (cnt_in < `PDMI_CNT_MIN) ? `PDMI_CNT_MIN : cnt_in;
            end else if (upd && bitc_ff == 3'h0 && busy) begin
                rep_ff <= rep_ff - 16'h0001;
            end
        end
    end
    // RULE1: clock and data from one divider
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= 4'h0;
            pclk_ff <= 1'b0;
            data_ff <= 1'b0;
            sh_ff <= 8'h00;
            bitc_ff <= 3'h0;
        end else if (clk_en) begin
            div_ff <= tick ? 4'h0 : div_ff + 4'h1;
            if (tick) begin
                pclk_ff <= ~pclk_ff;
            end
            if (stopped) begin
                bitc_ff <= 3'h0;
            end else if (upd) begin
                data_ff <= (bitc_ff == 3'h0) ? next_byte[7] : sh_ff[7];
                sh_ff <= (bitc_ff == 3'h0) ? {next_byte[6:0], 1'b0} : {sh_ff[6:0], 1'b0};
                bitc_ff <= bitc_ff + 3'h1;
            end
        end
    end
    assign hreadyout = ready_ff;
    assign hrdata = rdata_ff;
    assign hresp = 1'b0;
    assign link.pdm_clk = pclk_ff;
    assign link.pdm_serial_bit = data_ff;
endmodule : pdmi_src

// ### pdmi_chk.sv
// Assertions on the PDM link and the amplifier outputs
`timescale 1ns/1ns
`include "pdmi_map.svh"
module pdmi_chk #(
    parameter int LOSS_CYC = `PDMI_LOSS_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link
    input wire logic pdm_clk,
    input wire logic pdm_serial_bit,
    // Amplifier
    input wire logic power_stage_supply_ok,
    input wire logic vdd_ok,
    input wire logic smart_pd_en,
    input wire logic out_pos,
    input wire logic out_neg,
    input wire logic muted,
    input wire pdmi_pkg::pdmi_pwr_e pwr_state
);
    logic pclk_q_ff;
    logic [15:0] quiet_ff;
    logic [15:0] nxt_quiet;
    logic off_entry;
    // Cycles since the last bit clock change
    assign nxt_quiet = (pdm_clk != pclk_q_ff) ? 16'h0000 : quiet_ff + 16'h0001;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pclk_q_ff <= 1'b0;
            quiet_ff <= 16'h0000;
        end else begin
            pclk_q_ff <= pdm_clk;
            quiet_ff <= (quiet_ff == 16'hffff) ? quiet_ff : nxt_quiet;
        end
    end
    assign off_entry = (pwr_state == pdmi_pkg::PDMI_OFF);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_no_shoot_through: assert property (!(out_pos && out_neg))
        else $error("both outputs driven high");
    a_mute_silent: assert property (muted && $past(muted) |-> !out_pos && !out_neg)
        else $error("output pulse while muted");
    a_supply_reset: assert property (!(power_stage_supply_ok && vdd_ok) |=>
        !out_pos && !out_neg && !muted && pwr_state == pdmi_pkg::PDMI_RUN)
        else $error("low supply did not reset the amplifier");
    a_idle_silent: assert property ((pwr_state != pdmi_pkg::PDMI_RUN) &&
        ($past(pwr_state) != pdmi_pkg::PDMI_RUN) |-> !out_pos && !out_neg)
        else $error("output pulse outside run state");
    a_off_after_standby: assert property (off_entry && !$past(off_entry) |->
        $past(pwr_state) == pdmi_pkg::PDMI_STANDBY)
        else $error("power-down entered from other than standby");
    a_off_clock_quiet: assert property (off_entry && !$past(off_entry) |->
        quiet_ff >= LOSS_CYC / 2)
        else $error("power-down entered while bit clock active");
    a_standby_enabled: assert property ((pwr_state == pdmi_pkg::PDMI_STANDBY) &&
        ($past(pwr_state) == pdmi_pkg::PDMI_RUN) |-> $past(smart_pd_en))
        else $error("standby entered with smart power-down off");
    a_clk_half_period: assert property ($changed(pdm_clk) |=> $stable(pdm_clk) [*3])
        else $error("bit clock half period too short");
    a_data_on_edge: assert property ($changed(pdm_serial_bit) |-> $changed(pdm_clk))
        else $error("data moved away from a clock edge");

    c_muted: cover property (muted);
    c_standby: cover property (pwr_state == pdmi_pkg::PDMI_STANDBY);
    c_off: cover property (off_entry);
    c_pulse: cover property (out_pos || out_neg);
endmodule : pdmi_chk

// ### pdm_input_pattern_control_tb.sv
// Self-checking bench for the PDM source and amplifier pair
`timescale 1ns/1ns
`include "pdmi_map.svh"
module pdm_input_pattern_control_tb;
    localparam int LOSS = 40;
    localparam logic [7:0] PATS [7] = '{`PDMI_PAT_G3V6, `PDMI_PAT_G5V, `PDMI_PAT_RATE,
        `PDMI_PAT_EMI, `PDMI_PAT_HALF, `PDMI_PAT_SP32, `PDMI_PAT_G2V5};
    // Gain code, rate, emission, half pulse, 32 kHz
    localparam logic [5:0] EXPS [7] = '{6'h10, 6'h00, 6'h08, 6'h0c, 6'h0e, 6'h0f, 6'h2f};
    logic hclk, hresetn, hsel, hwrite, hreadyout;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic power_stage_supply_ok, vdd_ok, smart_pd_en, strap_high, strap_direct, chan_left;
    logic out_pos, out_neg, muted, rate_128, emi_low, half_pulse, special_32k;
    logic [5:0] amp_st;
    pdmi_pkg::pdmi_pwr_e pwr_state;
    pdmi_pkg::pdmi_gain_e gain_sel;
    int err_total, checks_done, n;
    pdmi_link_if link();
    assign amp_st = {gain_sel, rate_128, emi_low, half_pulse, special_32k};

    pdmi_src pdmi_src_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .link(link));
    pdmi_amp #(.REPEAT_MIN(128), .LOSS_CYC(LOSS)) pdmi_amp_inst (.hclk(hclk),
        .hresetn(hresetn), .clk_en(1'b1), .power_stage_supply_ok(power_stage_supply_ok),
        .vdd_ok(vdd_ok),
        .smart_pd_en(smart_pd_en), .gain_rate_strap_high(strap_high),
        .gain_rate_strap_direct(strap_direct), .channel_select_strap(chan_left), .link(link),
        .out_pos(out_pos), .out_neg(out_neg), .muted(muted), .pwr_state(pwr_state),
        .gain_sel(gain_sel), .rate_128(rate_128), .emi_low(emi_low),
        .half_pulse(half_pulse), .special_32k(special_32k));
    pdmi_chk #(.LOSS_CYC(LOSS)) pdmi_chk_inst (.hclk(hclk), .hresetn(hresetn),
        .pdm_clk(link.pdm_clk), .pdm_serial_bit(link.pdm_serial_bit),
        .power_stage_supply_ok(power_stage_supply_ok),
        .vdd_ok(vdd_ok), .smart_pd_en(smart_pd_en), .out_pos(out_pos), .out_neg(out_neg),
        .muted(muted), .pwr_state(pwr_state));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH reg at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH out at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_out

    task automatic give_verdict();
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // Single word transfer, result of a read left in rd
    task automatic ahb_xfer(input logic [31:0] addr, input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= addr;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb_xfer

    task automatic wait_mute(input logic lvl);
        int k;
        k = 0;
        while (muted !== lvl && k < 12000) begin
            @(posedge hclk);
            k++;
        end
        chk_out({7'h0, muted}, {7'h0, lvl});
    endtask : wait_mute

    task automatic run_cmd(input logic [7:0] pat, input logic [15:0] cnt);
        ahb_xfer({24'h0, `PDMI_REG_CMD}, 1'b1, {8'h00, cnt, pat});
        wait_mute(1'b1);
        repeat (4) @(posedge hclk);
    endtask : run_cmd

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        power_stage_supply_ok = 1'b1;
        vdd_ok = 1'b1;
        smart_pd_en = 1'b0;
        strap_high = 1'b1;
        strap_direct = 1'b0;
        chan_left = 1'b0;
        err_total = 0;
        checks_done = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // Four strap states, each latched after a supply dip
        for (int i = 0; i < 4; i++) begin
            @(posedge hclk);
            power_stage_supply_ok <= i[1];
            vdd_ok <= ~i[1];
            strap_high <= i[0];
            strap_direct <= ~i[1];
            repeat (2) @(posedge hclk);
            power_stage_supply_ok <= 1'b1;
            vdd_ok <= 1'b1;
            repeat (4) @(posedge hclk);
            chk_out({5'h0, gain_sel, rate_128}, {5'h0, i[1] ? 2'h0 : 2'h1, ~i[0]});
        end
        chk_out({7'h0, rate_128}, 8'h00);
        // Register reset values, unmapped place, write and read back
        ahb_xfer({24'h0, `PDMI_REG_CTRL}, 1'b0, 32'h0);
        chk_reg(rd, 32'h0);
        ahb_xfer({24'h0, `PDMI_REG_AUDIO}, 1'b0, 32'h0);
        chk_reg(rd, {24'h0, `PDMI_AUDIO_RST});
        ahb_xfer(32'h40, 1'b0, 32'h0);
        chk_reg(rd, 32'h0);
        ahb_xfer({24'h0, `PDMI_REG_AUDIO}, 1'b1, 32'hff);
        ahb_xfer({24'h0, `PDMI_REG_AUDIO}, 1'b0, 32'h0);
        chk_reg(rd, 32'hff);
        // Full scale stream, right channel, fast clock
        ahb_xfer({24'h0, `PDMI_REG_CTRL}, 1'b1, 32'h5);
        n = 0;
        while (!(out_pos || out_neg) && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        chk_out({7'h0, out_pos || out_neg}, 8'h01);
        for (int k = 0; k < 7; k++) begin
            run_cmd(PATS[k], 16'h0080);
            chk_out({2'h0, amp_st}, {2'h0, EXPS[k]});
            wait_mute(1'b0);
        end
        // Stop pattern, then clock loss
        smart_pd_en <= 1'b1;
        run_cmd(`PDMI_PAT_STOP, 16'h00c8);
        chk_out({6'h0, pwr_state}, {6'h0, pdmi_pkg::PDMI_STANDBY});
        ahb_xfer({24'h0, `PDMI_REG_CTRL}, 1'b1, 32'h0);
        repeat (LOSS + 40) @(posedge hclk);
        chk_out({6'h0, pwr_state}, {6'h0, pdmi_pkg::PDMI_OFF});
        chk_out({2'h0, amp_st}, 8'h00);
        // Restart in left channel mode
        chan_left <= 1'b1;
        ahb_xfer({24'h0, `PDMI_REG_CTRL}, 1'b1, 32'h7);
        n = 0;
        while (pwr_state !== pdmi_pkg::PDMI_RUN && n < 8000) begin
            @(posedge hclk);
            n++;
        end
        chk_out({6'h0, pwr_state}, {6'h0, pdmi_pkg::PDMI_RUN});
        wait_mute(1'b0);
        run_cmd(`PDMI_PAT_EMI, 16'h0080);
        chk_out({7'h0, emi_low}, 8'h01);
        give_verdict();
    end

    initial begin
        #2000000;
        err_total++;
        give_verdict();
    end
endmodule : pdm_input_pattern_control_tb
